// ===== common/mpt_pkg.sv
`default_nettype none
package mpt_pkg;
   // ------------------------------------------------------------
   // register byte offsets (avalon word aligned)
   // ------------------------------------------------------------
   // seven address bits: the match block at 40 must be reachable
   localparam logic [6:0] OFF_INT_STATUS  = 7'h00;
   localparam logic [6:0] OFF_CONTROL     = 7'h04;
   localparam logic [6:0] OFF_COUNT       = 7'h08;
   localparam logic [6:0] OFF_PRESCALE    = 7'h0C;
   localparam logic [6:0] OFF_PRESC_CNT   = 7'h10;
   localparam logic [6:0] OFF_MATCH_CTRL  = 7'h14;
   localparam logic [6:0] OFF_PWM_CTRL    = 7'h18;
   localparam logic [6:0] OFF_LATCH_EN    = 7'h1C;
   localparam logic [6:0] OFF_INT_MASK    = 7'h20;
   localparam logic [6:0] OFF_MATCH_BASE  = 7'h40;
   localparam int         NUM_MATCH       = 7;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int CTRL_COUNT_EN = 0;
   localparam int CTRL_RESET    = 1;
   localparam int CTRL_PWM_EN   = 3;

   // match control: three bits per match (interrupt, reset, stop)
   localparam int MC_INT  = 0;
   localparam int MC_RST  = 1;
   localparam int MC_STOP = 2;

   // pwm control: bits 2..6 pick double edge, bits 9..14 enable outputs
   localparam int PC_SEL_LSB = 2;
   localparam int PC_ENA_LSB = 9;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
   localparam int          WAIT_CYCLES    = 1;
endpackage : mpt_pkg
`default_nettype wire

// ===== src/mpt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mpt_timer
   import mpt_pkg::*;
#(
   parameter int NUM_OUT = 6
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [6:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [6:1]       pwm_out,
   output logic             irq
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (NUM_OUT != 6) begin : g_bad
      $error("mpt_timer supports exactly six outputs");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] count_reg;
   logic [31:0] presc_reg;
   logic [31:0] presc_cnt_reg;
   logic [3:0]  control_reg;
   logic [20:0] match_ctrl_reg;
   logic [14:0] pwm_ctrl_reg;
   logic [6:0]  latch_en_reg;
   logic [6:0]  int_status_reg;
   logic [6:0]  int_mask_reg;
   logic [31:0] shadow_reg [NUM_MATCH];
   logic [31:0] active_reg [NUM_MATCH];
   logic [6:1]  pwm_reg;
   logic        ack_reg;

   // byte-lane merge used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire       access    = avs_read | avs_write;
   wire       wr_go     = avs_write & ack_reg;
   wire       rd_go     = avs_read & ack_reg;
   wire       match_sel = avs_address >= OFF_MATCH_BASE &&
                          avs_address < OFF_MATCH_BASE + 7'(4 * NUM_MATCH);
   wire [2:0] match_idx = 3'((avs_address - OFF_MATCH_BASE) >> 2);
   // one wait cycle so read data can come from a flop
   assign avs_waitrequest = access & ~ack_reg;

   // ------------------------------------------------------------
   // counting and match detection
   // ------------------------------------------------------------
   wire        count_en   = control_reg[CTRL_COUNT_EN] & ~control_reg[CTRL_RESET];
   wire        presc_hit  = count_en && (presc_cnt_reg == presc_reg);
   logic [6:0] match_hit;
   always_comb begin
      for (int m = 0; m < NUM_MATCH; m++) begin
         match_hit[m] = presc_hit && (count_reg == active_reg[m]);
      end
   end
   logic any_reset;
   logic any_stop;
   always_comb begin
      any_reset = 1'b0;
      any_stop  = 1'b0;
      for (int m = 0; m < NUM_MATCH; m++) begin
         any_reset |= match_hit[m] & match_ctrl_reg[3*m + MC_RST];
         any_stop  |= match_hit[m] & match_ctrl_reg[3*m + MC_STOP];
      end
   end
   wire pwm_mode    = control_reg[CTRL_PWM_EN];
   // in pwm mode the cycle match always ends the period
   wire cycle_end   = match_hit[0] & (pwm_mode | match_ctrl_reg[MC_RST]);
   wire cnt_restart = any_reset | (pwm_mode & match_hit[0]);

   // prescaler and counter
   always_ff @(posedge clk) begin
      if (rst || control_reg[CTRL_RESET]) begin
         presc_cnt_reg <= RESET_ZERO;
         count_reg     <= RESET_ZERO;
      end else if (count_en) begin
         presc_cnt_reg <= presc_hit ? RESET_ZERO : presc_cnt_reg + 32'h1;
         if (presc_hit) begin
            count_reg <= cnt_restart ? RESET_ZERO : count_reg + 32'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // match registers: shadow written by software, active used
   // ------------------------------------------------------------
   // in pwm mode releases are consumed at the period boundary so no half-cycle edits leak out; in timer mode writes reach active at once
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int m = 0; m < NUM_MATCH; m++) begin
            shadow_reg[m] <= RESET_ZERO;
            active_reg[m] <= RESET_ZERO;
         end
      end else begin
         for (int m = 0; m < NUM_MATCH; m++) begin
            if (wr_go && match_sel && match_idx == 3'(m)) begin
               shadow_reg[m] <= merge(shadow_reg[m], avs_writedata, avs_byteenable);
            end
            if (!pwm_mode) begin
               if (wr_go && match_sel && match_idx == 3'(m)) begin
                  active_reg[m] <= merge(shadow_reg[m], avs_writedata, avs_byteenable);
               end
            end else if (cycle_end && latch_en_reg[m]) begin
               active_reg[m] <= shadow_reg[m];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pwm outputs
   // ------------------------------------------------------------
   logic [6:1] pwm_next;
   always_comb begin
      for (int n = 1; n <= 6; n++) begin
         // outputs 2..6 may be double edge using match n-1 set, match n reset
         if (n >= PC_SEL_LSB && n <= 6 && pwm_ctrl_reg[n]) begin
            if (match_hit[n]) begin
               pwm_next[n] = 1'b0;
            end else if (match_hit[n-1]) begin
               pwm_next[n] = 1'b1;
            end else begin
               pwm_next[n] = pwm_reg[n];
            end
         end else begin
            if (match_hit[n]) begin
               pwm_next[n] = 1'b0;
            end else if (cycle_end) begin
               pwm_next[n] = 1'b1;
            end else begin
               pwm_next[n] = pwm_reg[n];
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst || !pwm_mode) begin
         pwm_reg <= 6'h00;
      end else begin
         pwm_reg <= pwm_next;
      end
   end
   // disabled outputs sit constantly low
   assign pwm_out = pwm_reg & pwm_ctrl_reg[PC_ENA_LSB +: 6];

   // ------------------------------------------------------------
   // control, status and release registers
   // ------------------------------------------------------------
   wire wr_ctrl  = wr_go && avs_address == OFF_CONTROL;
   wire rd_stat  = rd_go && avs_address == OFF_INT_STATUS;
   wire [6:0] int_events = match_hit & {match_ctrl_reg[18], match_ctrl_reg[15],
                           match_ctrl_reg[12], match_ctrl_reg[9], match_ctrl_reg[6],
                           match_ctrl_reg[3], match_ctrl_reg[0]};
   always_ff @(posedge clk) begin
      if (rst) begin
         control_reg    <= 4'h0;
         presc_reg      <= RESET_ZERO;
         match_ctrl_reg <= 21'h0;
         pwm_ctrl_reg   <= 15'h0;
         latch_en_reg   <= 7'h00;
         int_mask_reg   <= 7'h00;
         int_status_reg <= 7'h00;
      end else begin
         if (wr_ctrl) begin
            control_reg <= 4'(merge(32'(control_reg), avs_writedata, avs_byteenable));
         end else if (any_stop) begin
            control_reg[CTRL_COUNT_EN] <= 1'b0;
         end
         if (wr_go && avs_address == OFF_PRESCALE) begin
            presc_reg <= merge(presc_reg, avs_writedata, avs_byteenable);
         end
         if (wr_go && avs_address == OFF_MATCH_CTRL) begin
            match_ctrl_reg <= 21'(merge(32'(match_ctrl_reg), avs_writedata, avs_byteenable));
         end
         if (wr_go && avs_address == OFF_PWM_CTRL) begin
            pwm_ctrl_reg <= 15'(merge(32'(pwm_ctrl_reg), avs_writedata, avs_byteenable));
         end
         if (wr_go && avs_address == OFF_INT_MASK) begin
            int_mask_reg <= 7'(merge(32'(int_mask_reg), avs_writedata, avs_byteenable));
         end
         // release bits clear once the transfer happened; a new set wins
         if (wr_go && avs_address == OFF_LATCH_EN) begin
            latch_en_reg <= 7'(merge(32'(latch_en_reg), avs_writedata, avs_byteenable));
         end else if (pwm_mode && cycle_end) begin
            latch_en_reg <= 7'h00;
         end
         // read clears status, but an event in the same cycle stays
         int_status_reg <= (rd_stat ? 7'h00 : int_status_reg) | int_events;
      end
   end
   assign irq = |(int_status_reg & int_mask_reg);

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = RESET_ZERO;
      if (match_sel) begin
         rd_mux = shadow_reg[match_idx];
      end else begin
         unique case (avs_address)
            OFF_INT_STATUS: rd_mux = 32'(int_status_reg);
            OFF_CONTROL:    rd_mux = 32'(control_reg);
            OFF_COUNT:      rd_mux = count_reg;
            OFF_PRESCALE:   rd_mux = presc_reg;
            OFF_PRESC_CNT:  rd_mux = presc_cnt_reg;
            OFF_MATCH_CTRL: rd_mux = 32'(match_ctrl_reg);
            OFF_PWM_CTRL:   rd_mux = 32'(pwm_ctrl_reg);
            OFF_LATCH_EN:   rd_mux = 32'(latch_en_reg);
            OFF_INT_MASK:   rd_mux = 32'(int_mask_reg);
            default:        rd_mux = RESET_ZERO;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg      <= 1'b0;
         avs_readdata <= RESET_ZERO;
      end else begin
         ack_reg <= access & ~ack_reg;
         if (avs_read && !ack_reg) begin
            avs_readdata <= rd_mux;
         end
      end
   end

endmodule : mpt_timer
`default_nettype wire

// ===== test/mpt_pwm_load.sv
`timescale 1ns/1ps
`default_nettype none
module mpt_pwm_load (
   input wire logic       clk,
   input wire logic [6:1] drive
);
   // ----------------------------------------
   // load stage: measures high time and period
   // ----------------------------------------
   logic [15:0] since  [6:1];
   logic [15:0] run    [6:1];
   logic [15:0] hi_len [6:1];
   logic [15:0] per_len[6:1];
   logic [6:1]  prev;
   // a driver stage only sees levels, so both figures are taken in clocks
   always_ff @(posedge clk) begin
      prev <= drive;
      for (int i = 1; i <= 6; i++) begin
         since[i] <= (drive[i] && !prev[i]) ? 16'h0001 : since[i] + 16'h0001;
         run[i]   <= drive[i] ? run[i] + 16'h0001 : 16'h0000;
         if (drive[i] && !prev[i]) per_len[i] <= since[i];
         if (!drive[i] && prev[i]) hi_len[i] <= run[i];
      end
   end
endmodule : mpt_pwm_load
`default_nettype wire

// ===== test/mpt_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mpt_timer_monitor
   import mpt_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [6:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [6:1]  pwm_out,
   input wire logic        irq
);
   // ----------------------------------------
   // port checks
   // ----------------------------------------
   // a full-word write taken at this edge
   logic wr_ok;
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req_start;
      $rose(avs_read || avs_write);
   endsequence
   a_wait_first: assert property (s_req_start |-> avs_waitrequest)
      else $error("request taken without wait state");
   a_wait_one: assert property (s_req_start |=> !avs_waitrequest)
      else $error("answer not one cycle late");
   a_reset_quiet: assert property ($fell(rst) |-> pwm_out == 6'h00 && !irq)
      else $error("outputs active after reset");
   a_reset_rdata: assert property ($fell(rst) |-> avs_readdata == RESET_ZERO)
      else $error("read data not cleared by reset");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 7'h24
      |-> avs_readdata == RESET_ZERO) else $error("unmapped read not zero");
   a_rdata_hold: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
      else $error("read data moved while idle");
   a_disable_low: assert property (wr_ok && avs_address == OFF_PWM_CTRL &&
      !avs_writedata[PC_ENA_LSB] |-> ##2 !pwm_out[1]) else $error("disabled output high");
   a_mask_off: assert property (wr_ok && avs_address == OFF_INT_MASK &&
      avs_writedata == RESET_ZERO |-> ##2 !irq) else $error("masked interrupt raised");
endmodule : mpt_timer_monitor
bind mpt_timer mpt_timer_monitor u_mon (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

// ===== test/mpt_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mpt_timer_tb_top
   import mpt_pkg::*;
;
   // ----------------------------------------
   // stimulus and checking
   // ----------------------------------------
   localparam int PR = 1;
   localparam int P  = (4 + 1) * (PR + 1);
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [6:0]  avs_address = 7'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [6:1]  pwm_out;
   logic        irq;
   logic [31:0] q;
   logic [31:0] saved;
   int          n_mismatch = 0;
   int          num_checks = 0;
   // free-running 100 MHz clock
   always #5 clk = ~clk;
   mpt_timer #(.NUM_OUT(6)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out), .irq(irq));
   mpt_pwm_load ld (.clk(clk), .drive(pwm_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one idle cycle before each request, so strobes never change twice per edge
   task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   // let a few periods pass, then judge one output at the load
   task automatic chk_out(input int i, input int hi, input int per);
      repeat (4 * P) @(posedge clk);
      check(32'(ld.hi_len[i]), 32'(hi));
      check(32'(ld.per_len[i]), 32'(per));
   endtask : chk_out
   task automatic t_regs();
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, 7'(4 * i), RESET_ZERO);
         check(q, RESET_ZERO);
      end
      check({25'h0, irq, pwm_out}, RESET_ZERO);
      bus(1'b1, 7'h24, 32'hFFFF_FFFF);
      bus(1'b0, 7'h24, RESET_ZERO);
      check(q, RESET_ZERO);
   endtask : t_regs
   task automatic t_pwm();
      bus(1'b1, OFF_PRESCALE, 32'(PR));
      bus(1'b1, OFF_MATCH_BASE, 32'h0000_0004);
      bus(1'b1, OFF_MATCH_BASE + 7'h04, 32'h0000_0001);
      bus(1'b1, OFF_MATCH_BASE + 7'h08, 32'h0000_0003);
      bus(1'b1, OFF_PWM_CTRL, 32'h0000_0600);
      bus(1'b1, OFF_CONTROL, 32'h0000_0009);
      chk_out(1, 2 * (PR + 1), P);
      chk_out(2, 4 * (PR + 1), P);
      // a held-back value must not reach the comparator
      bus(1'b1, OFF_MATCH_BASE + 7'h04, 32'h0000_0002);
      chk_out(1, 2 * (PR + 1), P);
      bus(1'b1, OFF_LATCH_EN, 32'h0000_0002);
      chk_out(1, 3 * (PR + 1), P);
      bus(1'b0, OFF_LATCH_EN, RESET_ZERO);
      check(q, RESET_ZERO);
   endtask : t_pwm
   task automatic t_double();
      // output 2 double edge: rise on match 1, fall on match 2
      bus(1'b1, OFF_PWM_CTRL, 32'h0000_0604);
      chk_out(2, 1 * (PR + 1), P);
      bus(1'b1, OFF_MATCH_BASE + 7'h04, 32'h0000_0003);
      bus(1'b1, OFF_MATCH_BASE + 7'h08, 32'h0000_0002);
      bus(1'b1, OFF_LATCH_EN, 32'h0000_0006);
      chk_out(2, 4 * (PR + 1), P);
      bus(1'b1, OFF_PWM_CTRL, 32'h0000_0408);
      for (int i = 0; i < P; i++) begin
         @(posedge clk);
         check({31'h0, pwm_out[1]}, RESET_ZERO);
      end
   endtask : t_double
   task automatic t_timer();
      bus(1'b1, OFF_CONTROL, 32'h0000_0002);
      bus(1'b1, OFF_MATCH_BASE + 7'h04, 32'h0000_0005);
      bus(1'b1, OFF_MATCH_CTRL, 32'h0000_0028);
      bus(1'b1, OFF_INT_MASK, 32'h0000_0002);
      bus(1'b1, OFF_CONTROL, 32'h0000_0001);
      repeat (3 * P) @(posedge clk);
      check({31'h0, irq}, 32'h0000_0001);
      bus(1'b0, OFF_CONTROL, RESET_ZERO);
      check(q, RESET_ZERO);
      bus(1'b0, OFF_COUNT, RESET_ZERO);
      saved = q;
      bus(1'b0, OFF_COUNT, RESET_ZERO);
      check(q, saved);
      bus(1'b1, OFF_INT_MASK, RESET_ZERO);
      @(posedge clk);
      check({31'h0, irq}, RESET_ZERO);
      bus(1'b0, OFF_INT_STATUS, RESET_ZERO);
      check(q & 32'h0000_0002, 32'h0000_0002);
      bus(1'b1, OFF_INT_MASK, 32'h0000_0002);
      @(posedge clk);
      check({31'h0, irq}, RESET_ZERO);
   endtask : t_timer
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // main sequence after twelve cycles of reset
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_pwm();
      t_double();
      t_timer();
      wrap_up();
   end
   // watchdog: the whole run needs well under 2000 cycles
   initial begin
      #50000;
      n_mismatch++;
      wrap_up();
   end
endmodule : mpt_timer_tb_top
`default_nettype wire
